//--- shared/opb_pkg.sv
// package: register map, field layout, reset values and states of the program buffer block
package opb_pkg;

	// ***********************************
	// register byte addresses
	// ***********************************
	localparam logic [31:0] OPB_ADDR_MODE   = 32'h07f40000; // mode register
	localparam logic [31:0] OPB_ADDR_STAT   = 32'h07f40004; // status register
	localparam logic [31:0] OPB_ADDR_PADDR  = 32'h07f40008; // program_address_buffer
	localparam logic [31:0] OPB_ADDR_PDATA  = 32'h07f4000c; // program_data_buffer
	localparam logic [31:0] OPB_ADDR_TIM1   = 32'h07f40010; // timing_config_first
	localparam logic [31:0] OPB_ADDR_IRQ_ST = 32'h07f40040; // interrupt status
	localparam logic [31:0] OPB_ADDR_IRQ_EN = 32'h07f40044; // interrupt enable
	localparam logic [31:0] OPB_ADDR_IRQ_CL = 32'h07f40048; // interrupt clear

	// ***********************************
	// fields and encodings
	// ***********************************
	localparam int          OPB_WADDR_W      = 12;
	localparam logic [11:0] OPB_WADDR_MAX    = 12'hbff; // 3071
	localparam logic [2:0]  OPB_MODE_PROGRAM = 3'h3;
	localparam int OPB_CPU_LSB  = 0;
	localparam int OPB_SHORT_LSB = 8;
	localparam int OPB_RD_LSB   = 12;
	localparam int OPB_LDO_LSB  = 16;
	localparam int OPB_SEL_RD_LSB = 20;
	localparam int OPB_SEL_PG_LSB = 24;
	localparam int OPB_STAT_IDLE_BIT  = 0;
	localparam int OPB_STAT_EMPTY_BIT = 1;
	localparam int OPB_STAT_MRDY_BIT  = 2;

	// ***********************************
	// reset values
	// ***********************************
	localparam logic [31:0] OPB_TIM1_RST   = 32'h0999100f;
	localparam logic [2:0]  OPB_MODE_RST   = 3'h0;
	localparam logic [1:0]  OPB_IRQ_EN_RST = 2'h0;

	// program engine states
	typedef enum logic [1:0] {
		OPB_IDLE,
		OPB_SEL_WAIT,
		OPB_PULSE,
		OPB_DONE
	} opb_state_t;

endpackage : opb_pkg

//--- verilog/opb_program_buffer.sv
// program request buffer, timing register and program sequencer of the memory controller
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module opb_program_buffer (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// memory array side
	output logic             mem_select,
	output logic             mem_program_mode_pulse,
	output logic      [11:0] mem_word_addr,
	output logic      [31:0] mem_word_data,
	// interrupt
	output logic             irq
);
	import opb_pkg::*;

	// ***********************************
	// registers
	// ***********************************
	// flow: software fills data, then address; an address write in program
	// mode raises launch, the idle engine copies the slot and frees it, then
	// selects the array, waits in microsecond ticks and gives one pulse
	// software-visible state; the buffer pair is the single request slot
	logic [2:0]  mode_r;
	logic [11:0] paddr_r;
	logic [31:0] pdata_r;
	logic [31:0] tim1_r;
	logic        empty_r;
	logic        idle_r;
	// engine copy: frees the buffer while the array is still busy
	logic [11:0] eng_addr_r;
	logic [31:0] eng_data_r;
	logic        launch_r;
	// microsecond divider and engine counters
	logic [7:0]  us_div_r;
	logic        us_tick_r;
	logic [6:0]  wait_r;
	logic [3:0]  pulse_r;
	// sequencer state and sticky interrupt bits
	opb_state_t  state_r;
	logic [1:0]  irq_st_r;
	logic [1:0]  irq_en_r;

	// decoded strobes and next values, all combinational
	logic        wr_paddr;
	logic        wr_pdata;
	logic        program_mode_mode;
	logic        take;
	logic        done_ev;
	logic [31:0] rd_nxt;
	logic [1:0]  irq_set;
	logic [1:0]  irq_clr;
	logic [1:0]  irq_st_nxt;
	logic        wr_mode;
	logic        wr_tim1;
	logic        wr_irq_en;
	logic        wr_irq_cl;

	// field extraction shared by several readers
	// a field wider than seven bits must not pass through here
	function automatic logic [6:0] opb_field(input logic [31:0] v,
		input int lsb, input int w);
		logic [31:0] s;
		s = (v >> lsb) & ((32'h1 << w) - 32'h1);
		return s[6:0];
	endfunction : opb_field

	// one decoder for every write strobe, so all registers see the same
	// address match
	function automatic logic opb_wr_hit(input logic wr,
		input logic [31:0] a, input logic [31:0] target);
		return wr && (a == target);
	endfunction : opb_wr_hit

	// ***********************************
	// write decode
	// ***********************************
	// program mode is a plain compare; no mode transition delay is
	// modelled, so the mode-ready status bit reads one at all times
	assign program_mode_mode = (mode_r == OPB_MODE_PROGRAM);
	// every register write goes through the same address match
	assign wr_mode   = opb_wr_hit(reg_wr, reg_addr, OPB_ADDR_MODE);
	assign wr_tim1   = opb_wr_hit(reg_wr, reg_addr, OPB_ADDR_TIM1);
	assign wr_irq_en = opb_wr_hit(reg_wr, reg_addr, OPB_ADDR_IRQ_EN);
	assign wr_irq_cl = opb_wr_hit(reg_wr, reg_addr, OPB_ADDR_IRQ_CL);
	// buffer writes are dropped while a request is pending, so a late
	// write can never alter the word the engine is about to copy
	assign wr_paddr  = opb_wr_hit(reg_wr, reg_addr, OPB_ADDR_PADDR)
		&& empty_r;
	assign wr_pdata  = opb_wr_hit(reg_wr, reg_addr, OPB_ADDR_PDATA)
		&& empty_r;
	// the engine takes a launch only between operations
	assign take      = launch_r && (state_r == OPB_IDLE);

	// mode register, reached at its own word
	// only bits 2:0 are kept; the rest read back as zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= OPB_MODE_RST;
		end else if (wr_mode) begin
			mode_r <= reg_wdata[2:0];
		end
	end

	// request buffer: address and data words
	// the address write stores its value in every mode; only the launch
	// below depends on program mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			paddr_r <= 12'h000;
			pdata_r <= 32'h00000000;
		end else begin
			if (wr_paddr) begin
				paddr_r <= reg_wdata[11:0];
			end
			// the data word may be rewritten any number of times before launch
			if (wr_pdata) begin
				pdata_r <= reg_wdata;
			end
		end
	end

	// timing register; bit 31 and bit 11 stay zero
	// the ldo and select-to-read waits belong to the power and read
	// sequencer; this block only programs, so it keeps and reads them back
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tim1_r <= OPB_TIM1_RST;
		end else if (wr_tim1) begin
			// reserved bits are dropped on the way in
			tim1_r <= reg_wdata & 32'h7ffff7ff;
		end
	end

	// launch and empty flag: a launch is held until the engine takes it
	// launch and empty are complements, so a launching write and a take
	// can never fall in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			empty_r  <= 1'b1;
			launch_r <= 1'b0;
		end else if (wr_paddr && program_mode_mode) begin
			empty_r  <= 1'b0;
			launch_r <= 1'b1;
		end else if (take) begin
			// the slot is free again once the engine holds its own copy
			empty_r  <= 1'b1;
			launch_r <= 1'b0;
		end
	end

	// ***********************************
	// microsecond tick
	// ***********************************
	// tick once every field+1 cycles. the divider runs free, so the first
	// tick of a wait lands up to one period early; a smaller new setting
	// is caught by the >= compare instead of wrapping through 255
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			us_div_r  <= 8'h00;
			us_tick_r <= 1'b0;
		end else if (us_div_r >= tim1_r[OPB_CPU_LSB +: 8]) begin
			us_div_r  <= 8'h00;
			us_tick_r <= 1'b1;
		end else begin
			// count up towards the field value
			us_div_r  <= us_div_r + 8'h01;
			us_tick_r <= 1'b0;
		end
	end

	// ***********************************
	// program engine
	// ***********************************
	// select, wait select-to-program, one pulse of read-access+1 cycles.
	// the ldo is taken to be on once program mode is entered; this engine
	// does not count the ldo wait itself, it only keeps the field.
	// select stays high from the take to the done cycle, so the array
	// never sees a pulse without select
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= OPB_IDLE;
			idle_r     <= 1'b1;
			wait_r     <= 7'h00;
			pulse_r    <= 4'h0;
			eng_addr_r <= 12'h000;
			eng_data_r <= 32'h00000000;
			mem_select <= 1'b0;
			mem_program_mode_pulse <= 1'b0;
		end else begin
			case (state_r)
				OPB_IDLE: begin
					// copy the slot so software may refill it at once
					if (take) begin
						eng_addr_r <= paddr_r;
						eng_data_r <= pdata_r;
						wait_r     <= opb_field(tim1_r, OPB_SEL_PG_LSB, 7);
						idle_r     <= 1'b0;
						mem_select <= 1'b1;
						state_r    <= OPB_SEL_WAIT;
					end
				end
				OPB_SEL_WAIT: begin
					// field+1 ticks in all: the wait counts down to zero
					if (us_tick_r) begin
						if (wait_r == 7'h00) begin
							// load the pulse length as the wait expires
							pulse_r <= 4'(opb_field(tim1_r,
								OPB_RD_LSB, 4));
							mem_program_mode_pulse <= 1'b1;
							state_r <= OPB_PULSE;
						end else begin
							wait_r <= wait_r - 7'h01;
						end
					end
				end
				OPB_PULSE: begin
					// the pulse stands field+1 cycles
					if (pulse_r == 4'h0) begin
						mem_program_mode_pulse <= 1'b0;
						state_r <= OPB_DONE;
					end else begin
						pulse_r <= pulse_r - 4'h1;
					end
				end
				OPB_DONE: begin
					// select drops and the engine reports idle
					mem_select <= 1'b0;
					idle_r     <= 1'b1;
					state_r    <= OPB_IDLE;
				end
				default: begin
					// an unused code returns to idle rather than hang the array
					state_r <= OPB_IDLE;
				end
			endcase
		end
	end

	// done lasts one cycle, the single cycle spent in the done state
	assign done_ev = (state_r == OPB_DONE);

	// memory word lines follow the engine copy
	// the one-cycle lag is harmless: the pulse comes microseconds later,
	// and the array sees stable words from the second cycle of the select window on
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_word_addr <= 12'h000;
			mem_word_data <= 32'h00000000;
		end else begin
			mem_word_addr <= eng_addr_r;
			mem_word_data <= eng_data_r;
		end
	end

	// ***********************************
	// interrupts
	// ***********************************
	// bit 0: programming done, bit 1: request taken (buffer free again)
	assign irq_set = {take, done_ev};
	// the clear register is write-only and reads zero
	assign irq_clr = wr_irq_cl ? reg_wdata[1:0] : 2'h0;
	// set wins over a clear in the same cycle, so no event is lost
	assign irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;

	// status, enable and the registered interrupt line
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_st_r <= 2'h0;
			irq_en_r <= OPB_IRQ_EN_RST;
			irq      <= 1'b0;
		end else begin
			irq_st_r <= irq_st_nxt;
			// the enable is a plain read/write register
			if (wr_irq_en) begin
				irq_en_r <= reg_wdata[1:0];
			end
			// irq rises in the same cycle as a new status bit, from the next-state value
			irq <= |(irq_st_nxt & irq_en_r);
		end
	end

	// ***********************************
	// read path
	// ***********************************
	// read mux; unmapped words and the clear register read zero
	always_comb begin
		rd_nxt = 32'h00000000;
		case (reg_addr)
			OPB_ADDR_MODE:   rd_nxt = {29'h0, mode_r};
			OPB_ADDR_STAT: begin
				rd_nxt[OPB_STAT_IDLE_BIT]  = idle_r;
				rd_nxt[OPB_STAT_EMPTY_BIT] = empty_r;
				// mode changes act at once, so mode-ready stays one
				rd_nxt[OPB_STAT_MRDY_BIT]  = 1'b1;
			end
			// upper address bits are not stored, so they read zero
			OPB_ADDR_PADDR:  rd_nxt = {20'h0, paddr_r};
			OPB_ADDR_PDATA:  rd_nxt = pdata_r;
			OPB_ADDR_TIM1:   rd_nxt = tim1_r;
			OPB_ADDR_IRQ_ST: rd_nxt = {30'h0, irq_st_r};
			OPB_ADDR_IRQ_EN: rd_nxt = {30'h0, irq_en_r};
			default:         rd_nxt = 32'h00000000;
		endcase
	end

	// data stand only in the cycle after the strobe
	// zero otherwise, so a stale word never lingers on the port
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= rd_nxt;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule : opb_program_buffer

`default_nettype wire

//--- bench/opb_checker.sv
// port checker of the program buffer block
`timescale 1ns/1ps
`default_nettype none
module opb_checker
	import opb_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// memory side
	input wire logic        mem_select,
	input wire logic        mem_program_mode_pulse
);
	logic [2:0]  mode_r;
	logic [31:0] tim_r;
	int          sel_r;
	int          pul_r;
	int          lo;
	int          hi;
	logic        wr_pa;
	logic        rd_st;
	assign wr_pa = reg_wr && reg_addr == OPB_ADDR_PADDR;
	assign rd_st = reg_rd && reg_addr == OPB_ADDR_STAT;
	// free tick: the first may land early, the last a period late
	assign lo = int'(tim_r[30:24]) * (int'(tim_r[7:0]) + 1);
	assign hi = lo + 2 * (int'(tim_r[7:0]) + 1) + 2;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// shadows of mode and timing, and cycle counts
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= OPB_MODE_RST;
			tim_r  <= OPB_TIM1_RST;
			sel_r  <= 0;
			pul_r  <= 0;
		end else begin
			if (reg_wr && reg_addr == OPB_ADDR_MODE) mode_r <= reg_wdata[2:0];
			if (reg_wr && reg_addr == OPB_ADDR_TIM1) tim_r <= reg_wdata;
			sel_r <= mem_select ? sel_r + 1 : 0;
			pul_r <= mem_program_mode_pulse ? pul_r + 1 : 0;
		end
	end
	property p_launch;
		wr_pa && mode_r == OPB_MODE_PROGRAM && !mem_select |-> ##2 mem_select;
	endproperty
	a_launch: assert property (p_launch) else $error("no launch");
	property p_store;
		wr_pa && mode_r != OPB_MODE_PROGRAM && !mem_select |=> !mem_select[*3];
	endproperty
	a_store: assert property (p_store) else $error("bad launch");
	property p_wait;
		$rose(mem_program_mode_pulse) |-> sel_r >= lo && sel_r <= hi;
	endproperty
	a_wait: assert property (p_wait) else $error("select wait");
	property p_width;
		$fell(mem_program_mode_pulse) |-> pul_r == int'(tim_r[15:12]) + 1;
	endproperty
	a_width: assert property (p_width) else $error("pulse width");
	property p_sel;
		mem_program_mode_pulse |-> mem_select;
	endproperty
	a_sel: assert property (p_sel) else $error("pulse unselected");
	property p_addr;
		reg_rd && reg_addr == OPB_ADDR_PADDR |=> reg_rdata[31:12] == 20'h0;
	endproperty
	a_addr: assert property (p_addr) else $error("address bits");
	property p_tim;
		reg_rd && reg_addr == OPB_ADDR_TIM1 |=> reg_rdata == (tim_r & 32'h7ffff7ff);
	endproperty
	a_tim: assert property (p_tim) else $error("timing read");
	property p_busy;
		rd_st && mem_select && sel_r < lo |=> !reg_rdata[OPB_STAT_IDLE_BIT];
	endproperty
	a_busy: assert property (p_busy) else $error("idle while busy");
endmodule : opb_checker
bind opb_program_buffer opb_checker opb_checker_inst (.core_clk, .rst_n,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_select,
	.mem_program_mode_pulse);
`default_nettype wire

//--- bench/opb_mem_model.sv
// memory array model: logs each word that gets a pulse
`timescale 1ns/1ps
`default_nettype none
module opb_mem_model (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst_n,
	// array side
	input wire logic        mem_select,
	input wire logic        mem_program_mode_pulse,
	input wire logic [11:0] mem_word_addr,
	input wire logic [31:0] mem_word_data
);
	logic [43:0] log_q[$];
	logic        pulse_d;
	// cells burn only while selected; word taken at pulse start
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_d <= 1'b0;
		end else begin
			pulse_d <= mem_program_mode_pulse;
			if (mem_program_mode_pulse && !pulse_d && mem_select) begin
				log_q.push_back({mem_word_addr, mem_word_data});
			end
		end
	end
endmodule : opb_mem_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench of the program buffer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import opb_pkg::*;
	logic        core_clk;
	logic        rst_n;
	logic [31:0] reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        mem_select;
	logic        mem_program_mode_pulse;
	logic [11:0] mem_word_addr;
	logic [31:0] mem_word_data;
	logic        irq;
	int          failures;
	int          num_checks;
	int          n;
	opb_program_buffer opb_program_buffer_inst (.core_clk, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_select,
		.mem_program_mode_pulse, .mem_word_addr, .mem_word_data, .irq);
	opb_mem_model opb_mem_model_inst (.core_clk, .rst_n, .mem_select,
		.mem_program_mode_pulse, .mem_word_addr, .mem_word_data);
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// strobe stays up so back-to-back writes assign it once per edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		reg_rd    <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		reg_wr   <= 1'b0;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		chk(reg_rdata, e);
	endtask : rd
	task automatic idle(input int c);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (c) @(posedge core_clk);
	endtask : idle
	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// a run needs a few hundred cycles; this allows far more
	initial begin
		#100us;
		failures++;
		results();
	end
	initial begin
		failures   = 0;
		num_checks = 0;
		rst_n      = 1'b0;
		reg_addr   = 32'h0;
		reg_wdata  = 32'h0;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(OPB_ADDR_STAT, 32'h7);
		rd(OPB_ADDR_TIM1, 32'h0999100f);
		rd(OPB_ADDR_PDATA, 32'h0);
		$display("reset test done");
		wr(OPB_ADDR_TIM1, 32'hffffffff);
		rd(OPB_ADDR_TIM1, 32'h7ffff7ff);
		// tick of 4 cycles, 10 ticks to pulse, pulse of 3 cycles
		wr(OPB_ADDR_TIM1, 32'h09002003);
		wr(OPB_ADDR_PDATA, 32'hcafe0001);
		wr(OPB_ADDR_PADDR, 32'hfffffbff);
		rd(OPB_ADDR_PADDR, 32'hbff);
		rd(OPB_ADDR_STAT, 32'h7);
		$display("store test done");
		// one request runs, one waits, a third is refused
		wr(OPB_ADDR_IRQ_EN, 32'h3);
		wr(OPB_ADDR_MODE, 32'h3);
		wr(OPB_ADDR_PDATA, 32'h12345678);
		wr(OPB_ADDR_PADDR, 32'h5);
		idle(3);
		wr(OPB_ADDR_PDATA, 32'ha5a5a5a5);
		wr(OPB_ADDR_PADDR, 32'hbfe);
		wr(OPB_ADDR_PDATA, 32'h0);
		wr(OPB_ADDR_PADDR, 32'h7);
		rd(OPB_ADDR_STAT, 32'h4);
		rd(OPB_ADDR_PDATA, 32'ha5a5a5a5);
		rd(OPB_ADDR_PADDR, 32'hbfe);
		for (n = 0; n < 400 && opb_mem_model_inst.log_q.size() < 2; n++) begin
			@(posedge core_clk);
		end
		idle(8);
		rd(OPB_ADDR_STAT, 32'h7);
		chk(64'(opb_mem_model_inst.log_q.size()), 64'h2);
		chk(opb_mem_model_inst.log_q[0], {12'h005, 32'h12345678});
		chk(opb_mem_model_inst.log_q[1], {12'hbfe, 32'ha5a5a5a5});
		rd(OPB_ADDR_IRQ_ST, 32'h3);
		chk(irq, 1'b1);
		wr(OPB_ADDR_IRQ_EN, 32'h0);
		idle(2);
		chk(irq, 1'b0);
		wr(OPB_ADDR_IRQ_EN, 32'h3);
		wr(OPB_ADDR_IRQ_CL, 32'h3);
		idle(2);
		chk(irq, 1'b0);
		rd(OPB_ADDR_IRQ_ST, 32'h0);
		rd(32'h07f40020, 32'h0);
		$display("program test done");
		results();
	end
endmodule : testbench
`default_nettype wire
